// ===== bench/abe_execute_asserts.sv
// Port-level timing and flag checks for the execute block
`timescale 1ns/1ps
module abe_execute_asserts #(
   parameter int PCW = 16
) (
   // Clock and reset
   input wire logic             clk,
   input wire logic             rst,
   // Issue side
   input wire logic             ce,
   input wire logic             issue,
   input wire abe_pkg::abe_op_t op,
   input wire logic [6:0]       branch_ofs,
   input wire logic [PCW-1:0]   pc_in,
   input wire logic [15:0]      z_ptr,
   // Results and registers
   input wire logic             ready,
   input wire logic             done,
   input wire logic [PCW-1:0]   pc_next,
   input wire logic             stack_we,
   input wire logic [15:0]      stack_addr,
   input wire logic [15:0]      stack_pointer,
   input wire logic [7:0]       status_flags
);
   // ==========================================================
   // Helpers
   wire logic           acc = issue && ready && ce;
   wire logic           nxv = status_flags[2] ^ status_flags[3];
   wire logic [PCW-1:0] tgt = pc_in + PCW'($signed(branch_ofs)) + PCW'(1);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // Properties
   property p_add_one;
      acc && op == abe_pkg::OP_ADD_REGS |=> done;
   endproperty
   a_add_one: assert property (p_add_one)
      else $error("add did not finish in one cycle");
   property p_word;
      acc && op == abe_pkg::OP_WORD_PLUS_IMMEDIATE |=> !done && !ready ##1 done;
   endproperty
   a_word: assert property (p_word)
      else $error("word add not two cycles");
   property p_jump;
      acc && op == abe_pkg::OP_JUMP_VIA_POINTER |=> !done ##1 done && pc_next == $past(z_ptr, 2);
   endproperty
   a_jump: assert property (p_jump)
      else $error("pointer jump target or timing wrong");
   property p_call;
      acc && op == abe_pkg::OP_CALL_VIA_POINTER |=> stack_we [*2] ##1 done;
   endproperty
   a_call: assert property (p_call)
      else $error("pointer call sequence wrong");
   // Push address is the pointer before its decrement
   property p_push;
      stack_we |-> stack_addr == stack_pointer + 16'h0001;
   endproperty
   a_push: assert property (p_push)
      else $error("stack write address off");
   property p_slt;
      acc && op == abe_pkg::OP_BRANCH_SIGNED_LESS && nxv |=>
         !done ##1 done && pc_next == $past(tgt, 2);
   endproperty
   a_slt: assert property (p_slt)
      else $error("signed less branch wrong");
   property p_sge_not;
      acc && op == abe_pkg::OP_BRANCH_SIGNED_GEQ && nxv |=>
         done && pc_next == $past(pc_in) + PCW'(1);
   endproperty
   a_sge_not: assert property (p_sge_not)
      else $error("untaken branch not one cycle");
   property p_and_c;
      acc && op == abe_pkg::OP_CONJUNCTION |=> status_flags[0] == $past(status_flags[0]);
   endproperty
   a_and_c: assert property (p_and_c)
      else $error("conjunction changed carry");
   cover property (acc && op == abe_pkg::OP_CALL_VIA_POINTER);
   cover property (acc && op == abe_pkg::OP_BRANCH_SIGNED_LESS && nxv);
   cover property (stack_we);
endmodule
bind abe_execute abe_execute_asserts #(.PCW(PCW)) u_asserts (.clk, .rst, .ce, .issue, .op,
   .branch_ofs, .pc_in, .z_ptr, .ready, .done, .pc_next, .stack_we, .stack_addr,
   .stack_pointer, .status_flags);

// ===== bench/abe_execute_tb.sv
// Self-checking bench for the execute block
`timescale 1ns/1ps
module abe_execute_tb;
   // ==========================================================
   // Signals
   logic             clk = 1'b0, rst = 1'b1, ce = 1'b1, issue = 1'b0;
   logic             next_is_long = 1'b0, io_we = 1'b0;
   abe_pkg::abe_op_t op = abe_pkg::OP_ADD_REGS;
   logic [7:0]       rd_val = 8'h00, rr_val = 8'h00, rd_hi_val = 8'h00;
   logic [7:0]       io_bit_val = 8'h00, io_wdata = 8'h00;
   logic [5:0]       word_imm = 6'h00, io_addr = 6'h00;
   logic [2:0]       bit_sel = 3'h0;
   logic [6:0]       branch_ofs = 7'h00;
   logic [15:0]      pc_in = 16'h0100, z_ptr = 16'h0000;
   logic             ready, done, rd_we, rd_hi_we, pc_load, stack_we;
   logic [7:0]       rd_wdata, rd_hi_wdata, stack_wdata, io_rdata, status_flags;
   logic [15:0]      pc_next, stack_addr, stack_pointer;
   int               err_count = 0, checks_done = 0, cyc;
   always #2 clk = ~clk;
   abe_execute uut (.clk, .rst, .ce, .issue, .op, .rd_val, .rr_val, .rd_hi_val, .word_imm,
      .bit_sel, .io_bit_val, .branch_ofs, .next_is_long, .pc_in, .z_ptr, .ready, .done,
      .rd_we, .rd_wdata, .rd_hi_we, .rd_hi_wdata, .pc_load, .pc_next, .stack_we,
      .stack_addr, .stack_wdata, .io_addr, .io_we, .io_wdata, .io_rdata, .status_flags,
      .stack_pointer);
   // ==========================================================
   // Shared tasks
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      checks_done++;
      if (e !== g) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic results();
      if (err_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Bounded wait so a lost done shows up as a wrong cycle count
   task automatic ex(abe_pkg::abe_op_t o, logic [7:0] a, logic [7:0] b);
      @(posedge clk) #1 op = o;
      rd_val = a;
      rr_val = b;
      issue = 1'b1;
      @(posedge clk) #1 issue = 1'b0;
      cyc = 1;
      while (done !== 1'b1 && cyc < 8) begin
         @(posedge clk) #1 cyc++;
      end
   endtask
   task automatic one(abe_pkg::abe_op_t o, logic [7:0] a, b, logic w, logic [7:0] r, m, f);
      ex(o, a, b);
      chk("rd_we", {15'h0000, w}, {15'h0000, rd_we});
      if (w)
         chk("rd_wdata", {8'h00, r}, {8'h00, rd_wdata});
      chk("flags", {8'h00, f}, {8'h00, status_flags & m});
      chk("cycles", 16'h0001, 16'(cyc));
   endtask
   task automatic pcc(abe_pkg::abe_op_t o, logic [7:0] a, b, logic [15:0] p, int c);
      logic [7:0] s;
      s = status_flags;
      ex(o, a, b);
      chk("pc_next", p, pc_next);
      chk("pc_load", 16'h0001, {15'h0000, pc_load});
      chk("cycles", 16'(c), 16'(cyc));
      chk("flags kept", {8'h00, s}, {8'h00, status_flags});
   endtask
   task automatic iow(logic [5:0] a, logic [7:0] d);
      @(posedge clk) #1 io_addr = a;
      io_wdata = d;
      io_we = 1'b1;
      @(posedge clk) #1 io_we = 1'b0;
   endtask
   task automatic ior(logic [5:0] a, logic [7:0] e);
      @(posedge clk) #1 io_addr = a;
      @(posedge clk) #1 chk("io_rdata", {8'h00, e}, {8'h00, io_rdata});
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_alu();
      one(abe_pkg::OP_ADD_REGS, 8'h0F, 8'h01, 1'b1, 8'h10, 8'h2F, 8'h20);
      one(abe_pkg::OP_ADD_REGS, 8'h80, 8'h80, 1'b1, 8'h00, 8'h2F, 8'h0B);
      one(abe_pkg::OP_ADD_WITH_CARRY, 8'h01, 8'h01, 1'b1, 8'h03, 8'h2F, 8'h00);
      one(abe_pkg::OP_MINUS, 8'h00, 8'h01, 1'b1, 8'hFF, 8'h2F, 8'h25);
      one(abe_pkg::OP_MINUS_WITH_BORROW, 8'h05, 8'h01, 1'b1, 8'h03, 8'h2F, 8'h00);
      one(abe_pkg::OP_ADD_REGS, 8'h80, 8'h80, 1'b1, 8'h00, 8'h2F, 8'h0B);
      one(abe_pkg::OP_CONJUNCTION, 8'hF0, 8'h3C, 1'b1, 8'h30, 8'h0F, 8'h01);
      one(abe_pkg::OP_DISJUNCTION, 8'hF0, 8'h0C, 1'b1, 8'hFC, 8'h0F, 8'h05);
      one(abe_pkg::OP_EXCLUSIVE_DISJUNCTION, 8'hF0, 8'hF0, 1'b1, 8'h00, 8'h0F, 8'h03);
      one(abe_pkg::OP_CLEAR_BITS_MASK, 8'hF0, 8'h30, 1'b1, 8'hC0, 8'h0F, 8'h05);
      one(abe_pkg::OP_SET_BITS_MASK, 8'h01, 8'h80, 1'b1, 8'h81, 8'h0F, 8'h05);
      one(abe_pkg::OP_INCREMENT, 8'h7F, 8'h00, 1'b1, 8'h80, 8'h0F, 8'h0D);
      one(abe_pkg::OP_DECREMENT, 8'h80, 8'h00, 1'b1, 8'h7F, 8'h0F, 8'h09);
      one(abe_pkg::OP_ZERO_REGISTER, 8'h55, 8'h00, 1'b1, 8'h00, 8'h0F, 8'h03);
      one(abe_pkg::OP_ZERO_SIGN_PROBE, 8'h80, 8'h00, 1'b0, 8'h00, 8'h0F, 8'h05);
      one(abe_pkg::OP_COMPARE_REGS, 8'h05, 8'h05, 1'b0, 8'h00, 8'h2F, 8'h02);
      one(abe_pkg::OP_COMPARE_REGS, 8'h03, 8'h04, 1'b0, 8'h00, 8'h2F, 8'h25);
      one(abe_pkg::OP_COMPARE_WITH_BORROW, 8'h04, 8'h03, 1'b0, 8'h00, 8'h2F, 8'h00);
   endtask
   task automatic t_word();
      word_imm = 6'h01;
      ex(abe_pkg::OP_WORD_PLUS_IMMEDIATE, 8'hFF, 8'h00);
      chk("word sum", 16'h0100, {rd_hi_wdata, rd_wdata});
      chk("rd_hi_we", 16'h0001, {15'h0000, rd_hi_we});
      chk("word flags", 16'h0000, {8'h00, status_flags & 8'h1F});
      ex(abe_pkg::OP_WORD_MINUS_IMMEDIATE, 8'h00, 8'h00);
      chk("word diff", 16'hFFFF, {rd_hi_wdata, rd_wdata});
      chk("word flags", 16'h0015, {8'h00, status_flags & 8'h1F});
      chk("cycles", 16'h0002, 16'(cyc));
   endtask
   task automatic t_flow();
      z_ptr = 16'h1234;
      pcc(abe_pkg::OP_JUMP_VIA_POINTER, 8'h00, 8'h00, 16'h1234, 2);
      iow(6'h3D, 8'h60);
      iow(6'h3E, 8'h02);
      ior(6'h3E, 8'h02);
      ior(6'h3C, 8'h00);
      z_ptr = 16'h0ABC;
      pcc(abe_pkg::OP_CALL_VIA_POINTER, 8'h00, 8'h00, 16'h0ABC, 3);
      chk("stack_pointer", 16'h025E, stack_pointer);
      chk("stack_addr", 16'h025F, stack_addr);
      chk("stack_wdata", 16'h0001, {8'h00, stack_wdata});
      next_is_long = 1'b1;
      pcc(abe_pkg::OP_SKIP_WHEN_EQUAL, 8'h5A, 8'h5A, 16'h0103, 2);
      pcc(abe_pkg::OP_SKIP_WHEN_EQUAL, 8'h5A, 8'h5B, 16'h0101, 1);
      next_is_long = 1'b0;
      bit_sel = 3'h3;
      io_bit_val = 8'h08;
      pcc(abe_pkg::OP_SKIP_REG_BIT_CLEAR, 8'h00, 8'hF7, 16'h0102, 2);
      pcc(abe_pkg::OP_SKIP_REG_BIT_SET, 8'h00, 8'hF7, 16'h0101, 1);
      pcc(abe_pkg::OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 16'h0102, 2);
      pcc(abe_pkg::OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h00, 16'h0101, 1);
   endtask
   task automatic t_branch();
      localparam logic [7:0] SF = 8'hA5;
      iow(6'h3F, SF);
      ior(6'h3F, SF);
      branch_ofs = 7'h7D;
      for (int i = 0; i < 8; i++) begin
         bit_sel = 3'(i);
         pcc(abe_pkg::OP_BRANCH_FLAG_SET, 8'h00, 8'h00,
             SF[i] ? 16'h00FE : 16'h0101, SF[i] ? 2 : 1);
         pcc(abe_pkg::OP_BRANCH_FLAG_CLEAR, 8'h00, 8'h00,
             SF[i] ? 16'h0101 : 16'h00FE, SF[i] ? 1 : 2);
      end
      branch_ofs = 7'h3F;
      pcc(abe_pkg::OP_BRANCH_SIGNED_LESS, 8'h00, 8'h00, 16'h0140, 2);
      pcc(abe_pkg::OP_BRANCH_SIGNED_GEQ, 8'h00, 8'h00, 16'h0101, 1);
   endtask
   // ==========================================================
   // Sequence and watchdog
   initial begin
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      t_alu();
      t_word();
      t_flow();
      t_branch();
      results();
   end
   initial begin
      #20000 err_count++;
      results();
   end
endmodule

// ===== include/abe_map.svh
// Offsets, flag positions, reset values and cycle counts of the execute block
`ifndef ABE_MAP_SVH
`define ABE_MAP_SVH

// ==========================================================
// I/O register offsets
`define ABE_OFS_STACK_POINTER_LOW  6'h3D
`define ABE_OFS_STACK_POINTER_HIGH 6'h3E
`define ABE_OFS_STATUS_FLAGS       6'h3F

// ==========================================================
// Status flag positions
`define ABE_FLAG_C 0
`define ABE_FLAG_Z 1
`define ABE_FLAG_N 2
`define ABE_FLAG_V 3
`define ABE_FLAG_S 4
`define ABE_FLAG_H 5
`define ABE_FLAG_T 6
`define ABE_FLAG_I 7

// ==========================================================
// Reset values and cycle counts
`define ABE_RST_STATUS_FLAGS 8'h00
`define ABE_RST_STACK_POINTER 16'h0000
`define ABE_CYC_SHORT 2'h1
`define ABE_CYC_WORD  2'h2
`define ABE_CYC_JUMP  2'h2
`define ABE_CYC_TAKEN 2'h2
`define ABE_CYC_CALL  2'h3

`endif

// ===== include/abe_pkg.sv
// Types shared by the execute block and its users
package abe_pkg;

   // ==========================================================
   // Operation codes
   typedef enum logic [4:0] {
      OP_ADD_REGS, OP_ADD_WITH_CARRY,
      OP_MINUS, OP_MINUS_WITH_BORROW,
      OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE,
      OP_CONJUNCTION, OP_DISJUNCTION, OP_EXCLUSIVE_DISJUNCTION,
      OP_CLEAR_BITS_MASK, OP_SET_BITS_MASK,
      OP_INCREMENT, OP_DECREMENT, OP_ZERO_SIGN_PROBE, OP_ZERO_REGISTER,
      OP_COMPARE_REGS, OP_COMPARE_WITH_BORROW,
      OP_JUMP_VIA_POINTER, OP_CALL_VIA_POINTER,
      OP_SKIP_WHEN_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
      OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR,
      OP_BRANCH_SIGNED_GEQ, OP_BRANCH_SIGNED_LESS
   } abe_op_t;

   // ==========================================================
   // Sequencer states
   typedef enum logic {
      ST_IDLE,
      ST_BUSY
   } abe_state_t;

endpackage

// ===== logic/abe_execute.sv
// Arithmetic, logic, compare, skip and branch execute unit with status and stack registers
`timescale 1ns/1ps
`include "abe_map.svh"

module abe_execute #(
   parameter int PCW = 16
) (
   // Clock, reset, enable
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 ce,
   // Instruction issue
   input  wire logic                 issue,
   input  wire abe_pkg::abe_op_t     op,
   input  wire logic [7:0]           rd_val,
   input  wire logic [7:0]           rr_val,
   input  wire logic [7:0]           rd_hi_val,
   input  wire logic [5:0]           word_imm,
   input  wire logic [2:0]           bit_sel,
   input  wire logic [7:0]           io_bit_val,
   input  wire logic [6:0]           branch_ofs,
   input  wire logic                 next_is_long,
   input  wire logic [PCW-1:0]       pc_in,
   input  wire logic [15:0]          z_ptr,
   output logic                      ready,
   // Results
   output logic                      done,
   output logic                      rd_we,
   output logic [7:0]                rd_wdata,
   output logic                      rd_hi_we,
   output logic [7:0]                rd_hi_wdata,
   output logic                      pc_load,
   output logic [PCW-1:0]            pc_next,
   // Return address stack writes
   output logic                      stack_we,
   output logic [15:0]               stack_addr,
   output logic [7:0]                stack_wdata,
   // I/O register port
   input  wire logic [5:0]           io_addr,
   input  wire logic                 io_we,
   input  wire logic [7:0]           io_wdata,
   output logic [7:0]                io_rdata,
   output logic [7:0]                status_flags,
   output logic [15:0]               stack_pointer
);

   // ==========================================================
   // Byte arithmetic, result {c, h, v, r}
   function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin);
      logic [7:0] r;
      logic       c;
      logic       h;
      logic       v;
      r = a + b + {7'h00, cin};
      c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
      h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
      v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
      return {c, h, v, r};
   endfunction

   function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                        input logic bin);
      logic [7:0] r;
      logic       c;
      logic       h;
      logic       v;
      r = a - b - {7'h00, bin};
      c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      return {c, h, v, r};
   endfunction

   // ==========================================================
   // State
   abe_pkg::abe_state_t state_r;
   logic [1:0]          rem_r;
   logic [7:0]          status_flags_r;
   logic [15:0]         stack_pointer_r;
   logic [7:0]          res_pend_r;
   logic [7:0]          hi_pend_r;
   logic                wr_lo_pend_r;
   logic                wr_hi_pend_r;
   logic [PCW-1:0]      pc_pend_r;
   logic [7:0]          flg_pend_r;
   logic [15:0]         ret_addr_r;
   logic                call_r;
   logic                done_r;
   logic                rd_we_r;
   logic [7:0]          rd_wdata_r;
   logic                rd_hi_we_r;
   logic [7:0]          rd_hi_wdata_r;
   logic [PCW-1:0]      pc_next_r;
   logic                stack_we_r;
   logic [15:0]         stack_addr_r;
   logic [7:0]          stack_wdata_r;
   logic [7:0]          io_rdata_r;

   // ==========================================================
   // Decode
   logic [7:0]     res_nxt;
   logic [7:0]     hi_nxt;
   logic           wr_lo_nxt;
   logic           wr_hi_nxt;
   logic [PCW-1:0] pc_nxt;
   logic [7:0]     flg_nxt;
   logic [1:0]     cyc_nxt;
   logic           cond;

   wire logic [10:0]    sum_w   = add8(rd_val, rr_val,
                                       op == abe_pkg::OP_ADD_WITH_CARRY &&
                                       status_flags_r[`ABE_FLAG_C]);
   wire logic           borrow  = status_flags_r[`ABE_FLAG_C] &&
                                  (op == abe_pkg::OP_MINUS_WITH_BORROW ||
                                   op == abe_pkg::OP_COMPARE_WITH_BORROW);
   wire logic [10:0]    dif_w   = sub8(rd_val, rr_val, borrow);
   wire logic [15:0]    word_in = {rd_hi_val, rd_val};
   wire logic           word_up = (op == abe_pkg::OP_WORD_PLUS_IMMEDIATE);
   wire logic [15:0]    word_r  = word_up ? word_in + {10'h000, word_imm}
                                          : word_in - {10'h000, word_imm};
   wire logic [PCW-1:0] pc_seq  = pc_in + PCW'(1);
   wire logic [PCW-1:0] pc_skip = pc_in + (next_is_long ? PCW'(3) : PCW'(2));
   wire logic [PCW-1:0] pc_rel  = pc_in + PCW'({{9{branch_ofs[6]}}, branch_ofs}) + PCW'(1);
   wire logic           nv_xor  = status_flags_r[`ABE_FLAG_N] ^ status_flags_r[`ABE_FLAG_V];
   wire logic           accept  = ce && issue && state_r == abe_pkg::ST_IDLE;
   wire logic           fin     = ce && state_r == abe_pkg::ST_BUSY && rem_r == 2'h1;
   wire logic           commit  = (accept && cyc_nxt == `ABE_CYC_SHORT) || fin;
   wire logic           use_pnd = (state_r == abe_pkg::ST_BUSY);
   wire logic [7:0]     c_flg   = use_pnd ? flg_pend_r : flg_nxt;
   wire logic           io_sel_f = io_addr == `ABE_OFS_STATUS_FLAGS;
   wire logic           io_sel_l = io_addr == `ABE_OFS_STACK_POINTER_LOW;
   wire logic           io_sel_h = io_addr == `ABE_OFS_STACK_POINTER_HIGH;

   always_comb begin
      res_nxt   = rd_val;
      hi_nxt    = rd_hi_val;
      wr_lo_nxt = 1'b0;
      wr_hi_nxt = 1'b0;
      pc_nxt    = pc_seq;
      flg_nxt   = status_flags_r;
      cyc_nxt   = `ABE_CYC_SHORT;
      cond      = 1'b0;
      case (op)
         abe_pkg::OP_ADD_REGS, abe_pkg::OP_ADD_WITH_CARRY: begin
            res_nxt   = sum_w[7:0];
            wr_lo_nxt = 1'b1;
            flg_nxt[`ABE_FLAG_C] = sum_w[10];
            flg_nxt[`ABE_FLAG_H] = sum_w[9];
            flg_nxt[`ABE_FLAG_V] = sum_w[8];
         end
         abe_pkg::OP_MINUS, abe_pkg::OP_MINUS_WITH_BORROW,
         abe_pkg::OP_COMPARE_REGS, abe_pkg::OP_COMPARE_WITH_BORROW: begin
            res_nxt   = dif_w[7:0];
            wr_lo_nxt = (op == abe_pkg::OP_MINUS || op == abe_pkg::OP_MINUS_WITH_BORROW);
            flg_nxt[`ABE_FLAG_C] = dif_w[10];
            flg_nxt[`ABE_FLAG_H] = dif_w[9];
            flg_nxt[`ABE_FLAG_V] = dif_w[8];
         end
         abe_pkg::OP_WORD_PLUS_IMMEDIATE, abe_pkg::OP_WORD_MINUS_IMMEDIATE: begin
            res_nxt   = word_r[7:0];
            hi_nxt    = word_r[15:8];
            wr_lo_nxt = 1'b1;
            wr_hi_nxt = 1'b1;
            cyc_nxt   = `ABE_CYC_WORD;
            flg_nxt[`ABE_FLAG_V] = word_up ? (~rd_hi_val[7] & word_r[15])
                                           : (rd_hi_val[7] & ~word_r[15]);
            flg_nxt[`ABE_FLAG_C] = word_up ? (rd_hi_val[7] & ~word_r[15])
                                           : (~rd_hi_val[7] & word_r[15]);
         end
         abe_pkg::OP_CONJUNCTION, abe_pkg::OP_ZERO_SIGN_PROBE: begin
            // The probe tests one register against itself, whatever rr carries
            res_nxt   = rd_val & (op == abe_pkg::OP_ZERO_SIGN_PROBE ? rd_val : rr_val);
            wr_lo_nxt = (op == abe_pkg::OP_CONJUNCTION);
         end
         abe_pkg::OP_DISJUNCTION, abe_pkg::OP_SET_BITS_MASK: begin
            res_nxt   = rd_val | rr_val;
            wr_lo_nxt = 1'b1;
         end
         abe_pkg::OP_EXCLUSIVE_DISJUNCTION: begin
            res_nxt   = rd_val ^ rr_val;
            wr_lo_nxt = 1'b1;
         end
         abe_pkg::OP_CLEAR_BITS_MASK: begin
            res_nxt   = rd_val & (8'hFF - rr_val);
            wr_lo_nxt = 1'b1;
         end
         abe_pkg::OP_INCREMENT: begin
            res_nxt   = rd_val + 8'h01;
            wr_lo_nxt = 1'b1;
         end
         abe_pkg::OP_DECREMENT: begin
            res_nxt   = rd_val - 8'h01;
            wr_lo_nxt = 1'b1;
         end
         abe_pkg::OP_ZERO_REGISTER: begin
            res_nxt   = 8'h00;
            wr_lo_nxt = 1'b1;
         end
         abe_pkg::OP_JUMP_VIA_POINTER: begin
            pc_nxt  = PCW'(z_ptr);
            cyc_nxt = `ABE_CYC_JUMP;
         end
         abe_pkg::OP_CALL_VIA_POINTER: begin
            pc_nxt  = PCW'(z_ptr);
            cyc_nxt = `ABE_CYC_CALL;
         end
         abe_pkg::OP_SKIP_WHEN_EQUAL:   cond = (rd_val == rr_val);
         abe_pkg::OP_SKIP_REG_BIT_CLEAR: cond = ~rr_val[bit_sel];
         abe_pkg::OP_SKIP_REG_BIT_SET:  cond = rr_val[bit_sel];
         abe_pkg::OP_SKIP_IO_BIT_CLEAR: cond = ~io_bit_val[bit_sel];
         abe_pkg::OP_SKIP_IO_BIT_SET:   cond = io_bit_val[bit_sel];
         abe_pkg::OP_BRANCH_FLAG_SET:   cond = status_flags_r[bit_sel];
         abe_pkg::OP_BRANCH_FLAG_CLEAR: cond = ~status_flags_r[bit_sel];
         abe_pkg::OP_BRANCH_SIGNED_GEQ: cond = ~nv_xor;
         abe_pkg::OP_BRANCH_SIGNED_LESS: cond = nv_xor;
         default: ;
      endcase
      // Shared Z,N and, for logic ops, cleared V; skip and branch targets and cycle counts
      case (op)
         abe_pkg::OP_WORD_PLUS_IMMEDIATE, abe_pkg::OP_WORD_MINUS_IMMEDIATE: begin
            flg_nxt[`ABE_FLAG_Z] = (word_r == 16'h0000);
            flg_nxt[`ABE_FLAG_N] = word_r[15];
            flg_nxt[`ABE_FLAG_S] = word_r[15] ^ flg_nxt[`ABE_FLAG_V];
         end
         abe_pkg::OP_MINUS_WITH_BORROW, abe_pkg::OP_COMPARE_WITH_BORROW: begin
            // Borrow chain keeps Z only while every byte was zero
            flg_nxt[`ABE_FLAG_Z] = (res_nxt == 8'h00) & status_flags_r[`ABE_FLAG_Z];
            flg_nxt[`ABE_FLAG_N] = res_nxt[7];
         end
         abe_pkg::OP_ADD_REGS, abe_pkg::OP_ADD_WITH_CARRY,
         abe_pkg::OP_MINUS, abe_pkg::OP_COMPARE_REGS: begin
            flg_nxt[`ABE_FLAG_Z] = (res_nxt == 8'h00);
            flg_nxt[`ABE_FLAG_N] = res_nxt[7];
         end
         abe_pkg::OP_INCREMENT, abe_pkg::OP_DECREMENT: begin
            flg_nxt[`ABE_FLAG_Z] = (res_nxt == 8'h00);
            flg_nxt[`ABE_FLAG_N] = res_nxt[7];
            flg_nxt[`ABE_FLAG_V] = (op == abe_pkg::OP_INCREMENT) ? (res_nxt == 8'h80)
                                                                  : (res_nxt == 8'h7F);
         end
         abe_pkg::OP_CONJUNCTION, abe_pkg::OP_ZERO_SIGN_PROBE, abe_pkg::OP_DISJUNCTION,
         abe_pkg::OP_SET_BITS_MASK, abe_pkg::OP_EXCLUSIVE_DISJUNCTION,
         abe_pkg::OP_CLEAR_BITS_MASK, abe_pkg::OP_ZERO_REGISTER: begin
            flg_nxt[`ABE_FLAG_Z] = (res_nxt == 8'h00);
            flg_nxt[`ABE_FLAG_N] = res_nxt[7];
            flg_nxt[`ABE_FLAG_V] = 1'b0;
         end
         abe_pkg::OP_SKIP_WHEN_EQUAL, abe_pkg::OP_SKIP_REG_BIT_CLEAR,
         abe_pkg::OP_SKIP_REG_BIT_SET, abe_pkg::OP_SKIP_IO_BIT_CLEAR,
         abe_pkg::OP_SKIP_IO_BIT_SET: begin
            pc_nxt  = cond ? pc_skip : pc_seq;
            cyc_nxt = cond ? `ABE_CYC_TAKEN : `ABE_CYC_SHORT;
         end
         abe_pkg::OP_BRANCH_FLAG_SET, abe_pkg::OP_BRANCH_FLAG_CLEAR,
         abe_pkg::OP_BRANCH_SIGNED_GEQ, abe_pkg::OP_BRANCH_SIGNED_LESS: begin
            pc_nxt  = cond ? pc_rel : pc_seq;
            cyc_nxt = cond ? `ABE_CYC_TAKEN : `ABE_CYC_SHORT;
         end
         default: ;
      endcase
   end

   // ==========================================================
   // Sequencer and pending result
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= abe_pkg::ST_IDLE;
         rem_r   <= 2'h0;
         call_r  <= 1'b0;
      end else if (accept && cyc_nxt != `ABE_CYC_SHORT) begin
         state_r <= abe_pkg::ST_BUSY;
         rem_r   <= cyc_nxt - 2'h1;
         call_r  <= (op == abe_pkg::OP_CALL_VIA_POINTER);
      end else if (ce && state_r == abe_pkg::ST_BUSY) begin
         rem_r <= rem_r - 2'h1;
         if (rem_r == 2'h1) begin
            state_r <= abe_pkg::ST_IDLE;
            call_r  <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         res_pend_r   <= 8'h00;
         hi_pend_r    <= 8'h00;
         wr_lo_pend_r <= 1'b0;
         wr_hi_pend_r <= 1'b0;
         pc_pend_r    <= '0;
         flg_pend_r   <= 8'h00;
         ret_addr_r   <= 16'h0000;
      end else if (accept) begin
         res_pend_r   <= res_nxt;
         hi_pend_r    <= hi_nxt;
         wr_lo_pend_r <= wr_lo_nxt;
         wr_hi_pend_r <= wr_hi_nxt;
         pc_pend_r    <= pc_nxt;
         flg_pend_r   <= flg_nxt;
         ret_addr_r   <= 16'(pc_seq);
      end
   end

   // ==========================================================
   // Committed outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         done_r        <= 1'b0;
         rd_we_r       <= 1'b0;
         rd_hi_we_r    <= 1'b0;
         pc_next_r     <= '0;
         rd_wdata_r    <= 8'h00;
         rd_hi_wdata_r <= 8'h00;
      end else if (ce) begin
         done_r     <= commit;
         rd_we_r    <= commit && (use_pnd ? wr_lo_pend_r : wr_lo_nxt);
         rd_hi_we_r <= commit && (use_pnd ? wr_hi_pend_r : wr_hi_nxt);
         if (commit) begin
            pc_next_r     <= use_pnd ? pc_pend_r : pc_nxt;
            rd_wdata_r    <= use_pnd ? res_pend_r : res_nxt;
            rd_hi_wdata_r <= use_pnd ? hi_pend_r : hi_nxt;
         end
      end
   end

   // ==========================================================
   // Status flags and stack pointer; commit beats a flag port write, a push beats a stack pointer port write
   always_ff @(posedge clk) begin
      if (rst) begin
         status_flags_r <= `ABE_RST_STATUS_FLAGS;
      end else if (ce) begin
         if (commit) begin
            status_flags_r <= c_flg;
         end else if (io_we && io_sel_f) begin
            status_flags_r <= io_wdata;
         end
      end
   end

   // Return address goes out low byte first, low byte on accept, high byte in the first busy cycle
   wire logic push_lo = accept && op == abe_pkg::OP_CALL_VIA_POINTER;
   wire logic push_hi = ce && call_r && rem_r == 2'h2;

   always_ff @(posedge clk) begin
      if (rst) begin
         stack_pointer_r <= `ABE_RST_STACK_POINTER;
         stack_we_r      <= 1'b0;
         stack_addr_r    <= 16'h0000;
         stack_wdata_r   <= 8'h00;
      end else if (ce) begin
         stack_we_r <= push_lo || push_hi;
         if (push_lo || push_hi) begin
            stack_addr_r    <= stack_pointer_r;
            stack_wdata_r   <= push_lo ? pc_seq[7:0] : ret_addr_r[15:8];
            stack_pointer_r <= stack_pointer_r - 16'h0001;
         end else if (io_we && io_sel_l) begin
            stack_pointer_r[7:0] <= io_wdata;
         end else if (io_we && io_sel_h) begin
            stack_pointer_r[15:8] <= io_wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         io_rdata_r <= 8'h00;
      end else if (ce) begin
         io_rdata_r <= io_sel_f ? status_flags_r :
                       io_sel_l ? stack_pointer_r[7:0] :
                       io_sel_h ? stack_pointer_r[15:8] : 8'h00;
      end
   end

   // ==========================================================
   // Output wiring
   assign ready         = (state_r == abe_pkg::ST_IDLE);
   assign done          = done_r;
   assign pc_load       = done_r;
   assign pc_next       = pc_next_r;
   assign rd_we         = rd_we_r;
   assign rd_wdata      = rd_wdata_r;
   assign rd_hi_we      = rd_hi_we_r;
   assign rd_hi_wdata   = rd_hi_wdata_r;
   assign stack_we      = stack_we_r;
   assign stack_addr    = stack_addr_r;
   assign stack_wdata   = stack_wdata_r;
   assign io_rdata      = io_rdata_r;
   assign status_flags  = status_flags_r;
   assign stack_pointer = stack_pointer_r;

endmodule
